// ### pwm_frame_pkg.sv
package pwm_frame_pkg;

	// ****************************************
	// Frame layout
	// ****************************************
	localparam int FRAME_BITS = 112;
	localparam int PAYLOAD_BYTES = 11;
	localparam int USER_MAX_DATA = 9;
	localparam int USER_BLOCK_MAX = 128;
	localparam logic [2:0] HDR_RSVD = 3'h0;

	// Command codes; write code chosen to avoid clashing with the others
	localparam logic [2:0] CMD_PPS = 3'h0;
	localparam logic [2:0] CMD_SYNC = 3'h3;
	localparam logic [2:0] CMD_READ = 3'h2;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_USER = 3'h7;

	typedef struct packed {
		logic [2:0] cmd;
		logic [7:0] source_identifier;
		logic bcast;
		logic [7:0] destination_identifier;
		logic [2:0] rsvd;
		logic [87:0] payload;
		logic parity;
	} frame_t;

	// Time value loaded into an accumulator
	typedef struct packed {
		logic valid;
		logic [1:0] sel;
		logic [87:0] value;
	} tod_load_t;

	typedef struct packed {
		logic valid;
		logic [2:0] sel;
		logic [87:0] data;
	} sync_load_t;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_IDS = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_RADDR = 8'h0C;
	localparam logic [7:0] REG_RWDATA = 8'h10;
	localparam logic [7:0] REG_USER_TX = 8'h14;
	localparam logic [7:0] REG_USER_LEN = 8'h18;
	localparam logic [7:0] REG_USER_RX = 8'h1C;
	localparam logic [7:0] REG_RRDATA = 8'h20;
	localparam logic [7:0] REG_CMD = 8'h24;

	// Control fields
	localparam int CTRL_MASTER = 1;
	localparam int CTRL_PPS_FRAME = 2;
	localparam int CTRL_PPS_OUT = 3;
	localparam int CTRL_TOD_TX = 4;
	localparam int CTRL_TOD_RX = 6;
	localparam int CTRL_ALT_PPS = 8;
	localparam int CTRL_SYNC_TX = 9;
	localparam int CTRL_SYNC_RX = 12;
	localparam int CTRL_ASYNC = 15;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [7:0] OWN_ID_RESET = 8'h01;
	localparam logic [7:0] DEST_ID_RESET = 8'h02;

	// Symbol codes
	localparam logic [1:0] SYM_SPACE = 2'h0;
	localparam logic [1:0] SYM_ZERO = 2'h1;
	localparam logic [1:0] SYM_ONE = 2'h2;

	localparam int CARRIER_DIV = 8;
	localparam int RX_MIN_PERIOD = 4;

endpackage

// ### pwm_frame_channel_codec.sv
// Implementation choices: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps

module pwm_frame_channel_codec #(
	parameter int DIV = pwm_frame_pkg::CARRIER_DIV
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [3:0] tod_pps,
	input wire logic alt_pps,
	input wire logic [3:0][87:0] tod_time,
	input wire logic sync_tx_req,
	input wire logic [87:0] sync_tx_data,
	input wire logic carrier_in,
	output logic carrier_out,
	output logic [1:0] tod_tx_sel,
	output logic [2:0] sync_tx_sel,
	output pwm_frame_pkg::tod_load_t tod_load,
	output pwm_frame_pkg::sync_load_t sync_load,
	output logic pps_out
);

	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [15:0] ctrl;
		logic [7:0] own_id;
		logic [7:0] dest_id;
		logic bcast_req;
		logic [15:0] raddr;
		logic [31:0] rwdata;
		logic [31:0] rrdata;
		logic rr_done;
		logic [7:0] user_left;
		logic user_first;
		logic [71:0] ubuf;
		logic [3:0] ucnt;
		logic [71:0] rxbuf;
		logic [3:0] rx_cnt;
		logic [3:0] rx_pos;
		logic rx_first;
		logic [6:0] rx_left;
		logic [7:0] perr;
		logic [7:0] drops;
		logic pend_pps;
		logic [87:0] pps_tod;
		logic [15:0] pps_lat;
		logic pend_sync;
		logic pend_rread;
		logic pend_rwrite;
		logic pend_user;
		logic pend_reply;
		logic [15:0] reply_addr;
		logic [7:0] reply_dst;
		logic pend_lwr;
		logic [15:0] lwr_addr;
		logic [31:0] lwr_data;
		logic [111:0] tx_sh;
		logic [6:0] tx_bits;
		logic [7:0] car_cnt;
		logic [1:0] sym;
		logic tx_pin;
		logic rx_s1;
		logic rx_s2;
		logic rx_prev;
		logic [7:0] hi_cnt;
		logic [7:0] per_cnt;
		logic [111:0] rx_sh;
		logic [6:0] rx_n;
		pwm_frame_pkg::tod_load_t tod_load;
		pwm_frame_pkg::sync_load_t sync_load;
		logic pps_out;
	} state_t;

	state_t s;
	state_t next_s;
	logic rst_meta;
	logic rst_sync;

	// ****************************************
	// Reset release
	// ****************************************
	// Two stages so the release never lands mid-cycle for the logic
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta <= 1'b0;
			rst_sync <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync <= rst_meta;
		end
	end

	// Frame builder with own source identifier and even parity
	function automatic pwm_frame_pkg::frame_t build(input logic [2:0] cmd, input logic [7:0] src,
			input logic [7:0] dst, input logic bc, input logic [87:0] pl);
		pwm_frame_pkg::frame_t f;
		f.cmd = cmd;
		f.source_identifier = src;
		f.bcast = bc;
		f.destination_identifier = dst;
		f.rsvd = pwm_frame_pkg::HDR_RSVD;
		f.payload = pl;
		f.parity = 1'b0;
		f.parity = ^f;
		return f;
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic req;
		logic ok;
		logic wr_en;
		logic [7:0] wr_addr;
		logic [31:0] wr_data;
		logic pps_pulse;
		logic bc;
		logic [3:0] nu;
		logic rise;
		logic [1:0] rsym;
		logic [111:0] rf;
		pwm_frame_pkg::frame_t fr;
		logic [10:0] hi8;
		logic [10:0] per3;
		logic [10:0] per5;
		logic [87:0] pl;
		logic [7:0] hi_len;
		logic [7:0] newleft;
		logic [31:0] rimg;
		next_s = s;
		req = 1'b0;
		ok = 1'b0;
		wr_en = 1'b0;
		wr_addr = 8'h00;
		wr_data = 32'h0000_0000;
		pps_pulse = 1'b0;
		bc = 1'b0;
		nu = 4'h0;
		rise = 1'b0;
		rsym = pwm_frame_pkg::SYM_SPACE;
		rf = '0;
		fr = '0;
		hi8 = 11'h000;
		per3 = 11'h000;
		per5 = 11'h000;
		pl = '0;
		hi_len = 8'h00;
		newleft = 8'h00;
		rimg = 32'h0000_0000;
		next_s.tod_load.valid = 1'b0;
		next_s.sync_load.valid = 1'b0;
		next_s.pps_out = 1'b0;

		// Bus slave: one answer cycle, user port stalls while its frame waits
		req = (avs_read || avs_write) && !s.ack;
		ok = !(avs_write && avs_address == pwm_frame_pkg::REG_USER_TX && s.pend_user);
		next_s.ack = req && ok;
		if (req && ok && avs_read) begin
			case (avs_address)
				pwm_frame_pkg::REG_CTRL: next_s.rdata = {16'h0000, s.ctrl};
				pwm_frame_pkg::REG_IDS: next_s.rdata = {15'h0000, s.bcast_req, s.dest_id, s.own_id};
				pwm_frame_pkg::REG_STATUS: next_s.rdata = {s.drops, s.perr, 7'h00, s.rr_done,
					(s.tx_bits != 7'h00), s.pend_user, s.pend_pps, s.pend_sync, s.rx_cnt};
				pwm_frame_pkg::REG_RADDR: next_s.rdata = {16'h0000, s.raddr};
				pwm_frame_pkg::REG_RWDATA: next_s.rdata = s.rwdata;
				pwm_frame_pkg::REG_USER_LEN: next_s.rdata = {20'h00000, s.ucnt, s.user_left};
				pwm_frame_pkg::REG_USER_RX: begin
					// Pop one received byte; bit 8 marks valid
					if (s.rx_pos < s.rx_cnt) begin
						next_s.rdata = {14'h0000, s.rx_first, (s.rx_pos == 4'h0), s.rx_left, 1'b1,
							s.rxbuf[71 - 8 * s.rx_pos -: 8]};
						next_s.rx_pos = s.rx_pos + 4'h1;
					end else begin
						next_s.rdata = 32'h0000_0000;
					end
				end
				pwm_frame_pkg::REG_RRDATA: begin
					next_s.rdata = s.rrdata;
					next_s.rr_done = 1'b0;
				end
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end

		// Single write path: bus first, remote write frames when the bus is idle
		if (s.ack && avs_write) begin
			wr_en = 1'b1;
			wr_addr = avs_address;
			wr_data = avs_writedata;
		end else if (s.pend_lwr) begin
			wr_en = 1'b1;
			wr_addr = s.lwr_addr[7:0];
			wr_data = s.lwr_data;
			next_s.pend_lwr = 1'b0;
		end
		if (wr_en) begin
			case (wr_addr)
				pwm_frame_pkg::REG_CTRL: next_s.ctrl = wr_data[15:0];
				pwm_frame_pkg::REG_IDS: begin
					next_s.own_id = wr_data[7:0];
					next_s.dest_id = wr_data[15:8];
					next_s.bcast_req = wr_data[16];
				end
				pwm_frame_pkg::REG_RADDR: next_s.raddr = wr_data[15:0];
				pwm_frame_pkg::REG_RWDATA: next_s.rwdata = wr_data;
				pwm_frame_pkg::REG_USER_LEN: begin
					// New block, clamped to the block limit
					if (wr_data[7:0] > 8'(pwm_frame_pkg::USER_BLOCK_MAX)) begin
						next_s.user_left = 8'(pwm_frame_pkg::USER_BLOCK_MAX);
					end else begin
						next_s.user_left = wr_data[7:0];
					end
					next_s.user_first = 1'b1;
					next_s.ucnt = 4'h0;
				end
				pwm_frame_pkg::REG_USER_TX: begin
					if ({4'h0, s.ucnt} < s.user_left) begin
						nu = s.ucnt + 4'h1;
						next_s.ubuf[71 - 8 * s.ucnt -: 8] = wr_data[7:0];
						next_s.ucnt = nu;
						if (nu == 4'(pwm_frame_pkg::USER_MAX_DATA) || {4'h0, nu} == s.user_left) begin
							next_s.pend_user = 1'b1;
						end
					end
				end
				pwm_frame_pkg::REG_CMD: begin
					// Remote access is a master's job
					if (s.ctrl[pwm_frame_pkg::CTRL_MASTER]) begin
						next_s.pend_rread = s.pend_rread || wr_data[0];
						next_s.pend_rwrite = s.pend_rwrite || wr_data[1];
					end
					next_s.pend_sync = s.pend_sync || wr_data[2];
				end
				default: begin
				end
			endcase
		end

		// Second-pulse source and time capture
		if (s.ctrl[pwm_frame_pkg::CTRL_ALT_PPS]) begin
			pps_pulse = alt_pps;
		end else begin
			pps_pulse = tod_pps[s.ctrl[pwm_frame_pkg::CTRL_TOD_TX +: 2]];
		end
		if (pps_pulse && s.ctrl[pwm_frame_pkg::CTRL_PPS_FRAME]) begin
			next_s.pend_pps = 1'b1;
			next_s.pps_tod = tod_time[s.ctrl[pwm_frame_pkg::CTRL_TOD_TX +: 2]];
			next_s.pps_lat = 16'h0000;
		end else if (s.pend_pps) begin
			next_s.pps_lat = s.pps_lat + 16'h0001;
		end
		if (sync_tx_req) begin
			next_s.pend_sync = 1'b1;
		end

		// ****************************************
		// Encoder
		// ****************************************
		bc = s.bcast_req && s.ctrl[pwm_frame_pkg::CTRL_MASTER];
		case (s.sym)
			pwm_frame_pkg::SYM_ZERO: hi_len = 8'(DIV / 4);
			pwm_frame_pkg::SYM_ONE: hi_len = 8'((3 * DIV) / 4);
			default: hi_len = 8'(DIV / 2);
		endcase
		next_s.tx_pin = (s.car_cnt < hi_len);
		if (s.car_cnt == 8'(DIV - 1)) begin
			next_s.car_cnt = 8'h00;
			if (s.tx_bits != 7'h00) begin
				next_s.sym = s.tx_sh[111] ? pwm_frame_pkg::SYM_ONE : pwm_frame_pkg::SYM_ZERO;
				next_s.tx_sh = {s.tx_sh[110:0], 1'b0};
				next_s.tx_bits = s.tx_bits - 7'h01;
			end else begin
				// Gap symbol between frames; pick the next frame by priority
				next_s.sym = pwm_frame_pkg::SYM_SPACE;
				next_s.tx_bits = 7'(pwm_frame_pkg::FRAME_BITS);
				if (s.pend_pps) begin
					pl = s.pps_tod;
					if (s.ctrl[pwm_frame_pkg::CTRL_ASYNC]) begin
						pl = s.pps_tod + {72'h0, s.pps_lat};
					end
					next_s.tx_sh = build(pwm_frame_pkg::CMD_PPS, s.own_id, s.dest_id, bc, pl);
					// A pulse landing on the launch cycle stays pending
					next_s.pend_pps = pps_pulse && s.ctrl[pwm_frame_pkg::CTRL_PPS_FRAME];
				end else if (s.pend_reply) begin
					// Reply carries the register image as it stands at launch
					case (s.reply_addr[7:0])
						pwm_frame_pkg::REG_CTRL: rimg = {16'h0000, s.ctrl};
						pwm_frame_pkg::REG_IDS: rimg = {15'h0000, s.bcast_req, s.dest_id, s.own_id};
						pwm_frame_pkg::REG_RADDR: rimg = {16'h0000, s.raddr};
						pwm_frame_pkg::REG_RWDATA: rimg = s.rwdata;
						default: rimg = 32'h0000_0000;
					endcase
					next_s.tx_sh = build(pwm_frame_pkg::CMD_READ, s.own_id, s.reply_dst, 1'b0,
						{s.reply_addr, rimg, 40'h0});
					next_s.pend_reply = 1'b0;
				end else if (s.pend_sync) begin
					next_s.tx_sh = build(pwm_frame_pkg::CMD_SYNC, s.own_id, s.dest_id, bc,
						sync_tx_data);
					next_s.pend_sync = 1'b0;
				end else if (s.pend_rwrite) begin
					next_s.tx_sh = build(pwm_frame_pkg::CMD_WRITE, s.own_id, s.dest_id, bc,
						{s.raddr, s.rwdata, 40'h0});
					next_s.pend_rwrite = 1'b0;
				end else if (s.pend_rread) begin
					next_s.tx_sh = build(pwm_frame_pkg::CMD_READ, s.own_id, s.dest_id, bc,
						{s.raddr, 72'h0});
					next_s.pend_rread = 1'b0;
				end else if (s.pend_user) begin
					newleft = s.user_left - {4'h0, s.ucnt};
					next_s.tx_sh = build(pwm_frame_pkg::CMD_USER, s.own_id, s.dest_id, bc,
						{s.user_first, newleft[6:0], 4'h0, s.ucnt, s.ubuf});
					next_s.user_left = newleft;
					next_s.user_first = 1'b0;
					next_s.ucnt = 4'h0;
					next_s.ubuf = '0;
					next_s.pend_user = 1'b0;
				end else begin
					next_s.tx_bits = 7'h00;
				end
			end
		end else begin
			next_s.car_cnt = s.car_cnt + 8'h01;
		end

		// ****************************************
		// Decoder
		// ****************************************
		next_s.rx_s1 = carrier_in;
		next_s.rx_s2 = s.rx_s1;
		next_s.rx_prev = s.rx_s2;
		rise = s.rx_s2 && !s.rx_prev;
		if (rise) begin
			// Classify the finished carrier cycle by its high share
			hi8 = {s.hi_cnt, 3'h0};
			per3 = 11'(3 * s.per_cnt);
			per5 = 11'(5 * s.per_cnt);
			if (s.per_cnt < 8'(pwm_frame_pkg::RX_MIN_PERIOD)) begin
				rsym = pwm_frame_pkg::SYM_SPACE;
			end else if (hi8 < per3) begin
				rsym = pwm_frame_pkg::SYM_ZERO;
			end else if (hi8 > per5) begin
				rsym = pwm_frame_pkg::SYM_ONE;
			end
			next_s.hi_cnt = 8'h01;
			next_s.per_cnt = 8'h01;
			if (rsym == pwm_frame_pkg::SYM_SPACE) begin
				next_s.rx_n = 7'h00;
			end else begin
				rf = {s.rx_sh[110:0], (rsym == pwm_frame_pkg::SYM_ONE)};
				next_s.rx_sh = rf;
				next_s.rx_n = s.rx_n + 7'h01;
				if (s.rx_n == 7'(pwm_frame_pkg::FRAME_BITS - 1)) begin
					next_s.rx_n = 7'h00;
					fr = rf;
					if (^rf) begin
						next_s.perr = s.perr + 8'h01;
					end else if (fr.bcast || fr.destination_identifier == s.own_id) begin
						case (fr.cmd)
							pwm_frame_pkg::CMD_PPS: begin
								next_s.tod_load.valid = 1'b1;
								next_s.tod_load.sel = s.ctrl[pwm_frame_pkg::CTRL_TOD_RX +: 2];
								next_s.tod_load.value = fr.payload;
								next_s.pps_out = s.ctrl[pwm_frame_pkg::CTRL_PPS_OUT];
							end
							pwm_frame_pkg::CMD_SYNC: begin
								next_s.sync_load.valid = 1'b1;
								next_s.sync_load.sel = s.ctrl[pwm_frame_pkg::CTRL_SYNC_RX +: 3];
								next_s.sync_load.data = fr.payload;
							end
							pwm_frame_pkg::CMD_READ: begin
								if (s.ctrl[pwm_frame_pkg::CTRL_MASTER]) begin
									next_s.rrdata = fr.payload[71:40];
									next_s.rr_done = 1'b1;
								end else begin
									next_s.pend_reply = 1'b1;
									next_s.reply_addr = fr.payload[87:72];
									next_s.reply_dst = fr.source_identifier;
								end
							end
							pwm_frame_pkg::CMD_WRITE: begin
								next_s.pend_lwr = 1'b1;
								next_s.lwr_addr = fr.payload[87:72];
								next_s.lwr_data = fr.payload[71:40];
							end
							pwm_frame_pkg::CMD_USER: begin
								// No acknowledgement frame; an unread buffer is overwritten
								if (s.rx_pos < s.rx_cnt) begin
									next_s.drops = s.drops + 8'h01;
								end
								next_s.rxbuf = fr.payload[71:0];
								next_s.rx_first = fr.payload[87];
								next_s.rx_left = fr.payload[86:80];
								next_s.rx_cnt = (fr.payload[79:72] > 8'(pwm_frame_pkg::USER_MAX_DATA)) ?
									4'(pwm_frame_pkg::USER_MAX_DATA) : fr.payload[75:72];
								next_s.rx_pos = 4'h0;
							end
							default: begin
							end
						endcase
					end
				end
			end
		end else begin
			if (s.per_cnt != 8'hFF) begin
				next_s.per_cnt = s.per_cnt + 8'h01;
			end
			if (s.rx_s2 && s.hi_cnt != 8'hFF) begin
				next_s.hi_cnt = s.hi_cnt + 8'h01;
			end
		end
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk or negedge rst_sync) begin
		if (!rst_sync) begin
			s <= '0;
			s.ctrl <= pwm_frame_pkg::CTRL_RESET;
			s.own_id <= pwm_frame_pkg::OWN_ID_RESET;
			s.dest_id <= pwm_frame_pkg::DEST_ID_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from state
	assign avs_readdata = s.rdata;
	assign avs_waitrequest = !s.ack;
	assign carrier_out = s.tx_pin;
	assign tod_tx_sel = s.ctrl[pwm_frame_pkg::CTRL_TOD_TX +: 2];
	assign sync_tx_sel = s.ctrl[pwm_frame_pkg::CTRL_SYNC_TX +: 3];
	assign tod_load = s.tod_load;
	assign sync_load = s.sync_load;
	assign pps_out = s.pps_out;

endmodule // pwm_frame_channel_codec

// ### pwm_frame_channel_codec_properties.sv
`timescale 1ns/1ps
// ****************************************
// Port checks for the frame codec
// ****************************************
module pwm_frame_channel_codec_properties #(
	parameter int DIV = 8
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic carrier_out,
	input wire pwm_frame_pkg::tod_load_t tod_load,
	input wire pwm_frame_pkg::sync_load_t sync_load,
	input wire logic pps_out
);
	int per;
	int hi;
	logic co_q;
	logic seen;
	// Cycles since last carrier rise and length of the high phase
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			per <= 0;
			hi <= 0;
			co_q <= 1'b0;
			seen <= 1'b0;
		end else begin
			co_q <= carrier_out;
			seen <= seen | (carrier_out & ~co_q);
			per <= (carrier_out && !co_q) ? 1 : per + 1;
			hi <= carrier_out ? hi + 1 : 0;
		end
	end
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rstn);
	chk_ack_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
		else $error("waitrequest low too long");
	chk_ack_cause: assert property ($fell(avs_waitrequest) |-> $past(avs_read) || $past(avs_write))
		else $error("answer without request");
	chk_read_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
		else $error("read not answered next cycle");
	// First rise after reset has no reference, hence the seen flag
	chk_carrier_period: assert property (carrier_out && !co_q && seen |-> per == DIV)
		else $error("carrier period wrong");
	chk_carrier_duty: assert property (!carrier_out && co_q |-> hi * 4 == DIV || hi * 2 == DIV || hi * 4 == 3 * DIV)
		else $error("carrier high time wrong");
	chk_pps_pair: assert property (pps_out |-> tod_load.valid)
		else $error("pulse without time load");
	chk_tod_pulse: assert property (tod_load.valid |=> !tod_load.valid)
		else $error("time load not a pulse");
	chk_sync_pulse: assert property (sync_load.valid |=> !sync_load.valid)
		else $error("sync load not a pulse");
endmodule // pwm_frame_channel_codec_properties

bind pwm_frame_channel_codec pwm_frame_channel_codec_properties #(.DIV(DIV)) u_props (
	.clk(clk),
	.rstn(rstn),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest),
	.carrier_out(carrier_out),
	.tod_load(tod_load),
	.sync_load(sync_load),
	.pps_out(pps_out)
);

// ### pwm_far_end_model.sv
`timescale 1ns/1ps
// ****************************************
// Far timing device: carrier decoder and encoder
// ****************************************
module pwm_far_end_model #(
	parameter int DIV = 8,
	parameter int TNS = 80
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic carrier_out,
	output logic carrier_in,
	output logic [111:0] rx_frame,
	output logic rx_valid
);
	logic [111:0] tx_q[$];
	logic [111:0] sh;
	logic [111:0] f;
	logic b;
	int hi;
	int nb;
	// Symbol from high time at each fall; a space restarts the frame
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hi <= 0;
			nb <= 0;
			rx_valid <= 1'b0;
		end else begin
			rx_valid <= 1'b0;
			hi <= carrier_out ? hi + 1 : 0;
			if (!carrier_out && hi != 0) begin
				b = hi * 8 >= DIV * 5;
				if (hi * 8 > DIV * 3 && !b) begin
					nb <= 0;
				end else begin
					sh <= {sh[110:0], b};
					rx_frame <= {sh[110:0], b};
					rx_valid <= nb == 111;
					nb <= nb == 111 ? 0 : nb + 1;
				end
			end
		end
	end
	// One symbol per carrier cycle, rising edge never moves
	task automatic sym(input int h);
		carrier_in = 1'b1;
		#(h);
		carrier_in = 1'b0;
		#(TNS - h);
	endtask
	// Free-running carrier, phase unrelated to clk; never acknowledges
	initial begin
		carrier_in = 1'b0;
		#3;
		forever begin
			sym(TNS / 2);
			if (tx_q.size() != 0) begin
				f = tx_q.pop_front();
				for (int i = 111; i >= 0; i--) sym(f[i] ? TNS * 3 / 4 : TNS / 4);
			end
		end
	end
endmodule // pwm_far_end_model

// ### pwm_frame_channel_codec_tb.sv
`timescale 1ns/1ps
module pwm_frame_channel_codec_tb;
	logic clk;
	logic rstn;
	logic [7:0] avs_address;
	logic avs_read;
	logic avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [3:0] tod_pps;
	logic alt_pps;
	logic [3:0][87:0] tod_time;
	logic sync_tx_req;
	logic [87:0] sync_tx_data;
	logic carrier_in;
	logic carrier_out;
	logic [1:0] tod_tx_sel;
	logic [2:0] sync_tx_sel;
	pwm_frame_pkg::tod_load_t tod_load;
	pwm_frame_pkg::sync_load_t sync_load;
	logic pps_out;
	logic [111:0] fr;
	logic fr_v;
	logic [111:0] fq[$];
	logic [111:0] tq[$];
	logic [111:0] sq[$];
	logic [15:0] seed;
	logic [31:0] rd;
	logic [111:0] g;
	logic [87:0] t;
	logic [95:0] u;
	int num_errors;
	int num_checks;
	int np;
	pwm_frame_channel_codec #(.DIV(8)) u_dut (
		.clk(clk),
		.rstn(rstn),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.tod_pps(tod_pps),
		.alt_pps(alt_pps),
		.tod_time(tod_time),
		.sync_tx_req(sync_tx_req),
		.sync_tx_data(sync_tx_data),
		.carrier_in(carrier_in),
		.carrier_out(carrier_out),
		.tod_tx_sel(tod_tx_sel),
		.sync_tx_sel(sync_tx_sel),
		.tod_load(tod_load),
		.sync_load(sync_load),
		.pps_out(pps_out)
	);
	pwm_far_end_model #(.DIV(8), .TNS(80)) u_far (
		.clk(clk),
		.rstn(rstn),
		.carrier_out(carrier_out),
		.carrier_in(carrier_in),
		.rx_frame(fr),
		.rx_valid(fr_v)
	);
	// Capture frames and load pulses, which stand a single cycle
	always @(posedge clk) begin
		if (fr_v === 1'b1) fq.push_back(fr);
		if (tod_load.valid === 1'b1) tq.push_back({22'h0, tod_load.sel, tod_load.value});
		if (sync_load.valid === 1'b1) sq.push_back({21'h0, sync_load.sel, sync_load.data});
		if (pps_out === 1'b1) np++;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [87:0] r88();
		logic [95:0] v;
		v = '0;
		repeat (6) begin
			seed = lfsr(seed);
			v = {v[79:0], seed};
		end
		return v[87:0];
	endfunction
	// Expected frame with even parity over all bits
	function automatic logic [111:0] mk(input logic [2:0] c, input logic [7:0] d, input logic [87:0] p);
		return {c, 8'h5C, 1'b0, d, 3'h0, p, ^{c, 8'h5C, d, p}};
	endfunction
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [111:0] e, input logic [111:0] s);
		num_checks++;
		if (s !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, s);
		end
	endtask
	// Bounded wait on a capture queue
	task automatic pull(ref logic [111:0] q[$], output logic [111:0] v);
		for (int i = 0; i < 4000 && q.size() == 0; i++) @(posedge clk);
		if (q.size() == 0) begin
			num_errors++;
			close_out();
		end else begin
			v = q.pop_front();
		end
	endtask
	// Request held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (avs_waitrequest !== 1'b0 && i < 4000);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (i >= 4000) begin
			num_errors++;
			close_out();
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rstn, avs_address, avs_read, avs_write, avs_writedata, tod_pps, alt_pps, tod_time, sync_tx_req, sync_tx_data} = '0;
		seed = 16'hAED6;
		num_errors = 0;
		num_checks = 0;
		np = 0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		bus(0, pwm_frame_pkg::REG_IDS, 0);
		chk("ids", {pwm_frame_pkg::DEST_ID_RESET, pwm_frame_pkg::OWN_ID_RESET}, rd);
		bus(0, 8'h3C, 0);
		chk("unmapped", 0, rd);
		bus(1, pwm_frame_pkg::REG_IDS, 32'hA35C);
		// Each accumulator as second-pulse source and as update target
		for (int k = 0; k < 4; k++) begin
			bus(1, pwm_frame_pkg::REG_CTRL, 32'h0E + 32'(k) * 32'h50);
			t = r88();
			@(posedge clk);
			tod_time[k] <= t;
			tod_pps[k] <= 1'b1;
			@(posedge clk);
			tod_pps <= 4'h0;
			pull(fq, g);
			chk("pps frame", mk(pwm_frame_pkg::CMD_PPS, 8'hA3, t), g);
			chk("tod sel", k, tod_tx_sel);
			t = r88();
			u_far.tx_q.push_back(mk(pwm_frame_pkg::CMD_PPS, 8'h5C, t));
			pull(tq, g);
			chk("tod load", {k[1:0], t}, g);
		end
		// Alternate pulse while a sync frame is on the wire: launch delay lands in the time field
		bus(1, pwm_frame_pkg::REG_CTRL, 32'h81FE);
		bus(1, pwm_frame_pkg::REG_CMD, 32'h4);
		t = r88();
		repeat (10) @(posedge clk);
		tod_time[3] <= t;
		alt_pps <= 1'b1;
		@(posedge clk);
		alt_pps <= 1'b0;
		pull(fq, g);
		pull(fq, g);
		t = g[88:1] - t;
		chk("pps offset", {pwm_frame_pkg::CMD_PPS, 2'h3}, {g[111:109], t > 88'h8, t < 88'h388});
		// Wrong destination and bad parity dropped, broadcast taken
		t = r88();
		u_far.tx_q.push_back(mk(pwm_frame_pkg::CMD_PPS, 8'hA4, r88()));
		u_far.tx_q.push_back(mk(pwm_frame_pkg::CMD_PPS, 8'h5C, r88()) ^ 112'h1);
		u_far.tx_q.push_back(mk(pwm_frame_pkg::CMD_PPS, 8'hA4, t) ^ {11'h0, 1'b1, 99'h0, 1'b1});
		pull(tq, g);
		chk("bcast load", {2'h3, t}, g);
		bus(0, pwm_frame_pkg::REG_STATUS, 0);
		chk("parity errors", 8'h01, rd[23:16]);
		chk("pps out", 5, np);
		// Sync both ways; broadcast request ignored when not master
		bus(1, pwm_frame_pkg::REG_CTRL, 32'h5A00);
		bus(1, pwm_frame_pkg::REG_IDS, 32'h1A35C);
		t = r88();
		@(posedge clk);
		sync_tx_data <= t;
		sync_tx_req <= 1'b1;
		@(posedge clk);
		sync_tx_req <= 1'b0;
		pull(fq, g);
		chk("sync frame", mk(pwm_frame_pkg::CMD_SYNC, 8'hA3, t), g);
		chk("sync sel", 5, sync_tx_sel);
		t = r88();
		u_far.tx_q.push_back(mk(pwm_frame_pkg::CMD_SYNC, 8'h5C, t));
		pull(sq, g);
		chk("sync load", {3'h5, t}, g);
		// Far master writes then reads a register
		t = r88();
		u_far.tx_q.push_back(mk(pwm_frame_pkg::CMD_WRITE, 8'h5C, {16'h000C, t[31:0], 40'h0}));
		u_far.tx_q.push_back(mk(pwm_frame_pkg::CMD_READ, 8'h5C, {16'h000C, 72'h0}));
		pull(fq, g);
		chk("read reply", {pwm_frame_pkg::CMD_READ, 16'h000C, 16'h0000, t[15:0]}, {g[111:109], g[88:41]});
		bus(0, pwm_frame_pkg::REG_RADDR, 0);
		chk("remote write", {16'h0000, t[15:0]}, rd);
		bus(1, pwm_frame_pkg::REG_CTRL, 32'h2);
		bus(1, pwm_frame_pkg::REG_RWDATA, t[63:32]);
		bus(1, pwm_frame_pkg::REG_CMD, 32'h2);
		pull(fq, g);
		chk("write frame", {pwm_frame_pkg::CMD_WRITE, t[15:0], t[63:32]}, {g[111:109], g[88:41]});
		chk("bcast master", 1, g[100]);
		// Twelve-byte user block splits nine plus three
		bus(1, pwm_frame_pkg::REG_CTRL, 32'h0);
		bus(1, pwm_frame_pkg::REG_USER_LEN, 32'd12);
		u = {r88(), 8'hC3};
		for (int i = 0; i < 12; i++) bus(1, pwm_frame_pkg::REG_USER_TX, {24'h0, u[95 - 8 * i -: 8]});
		pull(fq, g);
		chk("user first", mk(pwm_frame_pkg::CMD_USER, 8'hA3, {16'h8309, u[95:24]}), g);
		pull(fq, g);
		chk("user last", mk(pwm_frame_pkg::CMD_USER, 8'hA3, {16'h0003, u[23:0], 48'h0}), g);
		// Received user byte reaches the receive port, no reply sent
		u_far.tx_q.push_back(mk(pwm_frame_pkg::CMD_USER, 8'h5C, {16'h8001, u[95:88], 64'h0}));
		rd = 0;
		for (int i = 0; i < 800 && rd[8] !== 1'b1; i++) bus(0, pwm_frame_pkg::REG_USER_RX, 0);
		chk("user rx", {10'h301, u[95:88]}, rd[17:0]);
		// Long enough for any answering frame to reach the far end
		repeat (1000) @(posedge clk);
		chk("no reply", 0, fq.size());
		close_out();
	end
endmodule // pwm_frame_channel_codec_tb
